// ### rtl/ccd_pkg.sv
// Constants shared by the current channel datapath and its per-channel compensation stage.
// Assumes a single 50 MHz DSP clock with all datapath strobes generated on that clock.
package ccd_pkg;
   // ==========================================================
   // Clock and sample rates
   localparam int CLK_HZ = 50_000_000;
   localparam int MOD_RATE_HZ = 64_000;
   localparam int SINC_RATE_HZ = 16_000;
   localparam int LPF_RATE_HZ = 4_000;
   localparam int ANGLE_RATE_HZ = 512_000;
   localparam int SINC_DECIM = MOD_RATE_HZ / SINC_RATE_HZ;
   localparam int LPF_DECIM = SINC_RATE_HZ / LPF_RATE_HZ;
   localparam int ANGLE_TICK_CYCLES = CLK_HZ / ANGLE_RATE_HZ;
   localparam logic [7:0] ANGLE_TICK_LAST = 8'(ANGLE_TICK_CYCLES - 1);

   // ==========================================================
   // Widths and filter shifts
   localparam int MOD_W = 16;
   localparam int SAMP_W = 24;
   localparam int CFG_W = 4;
   localparam int ANG_W = 16;
   localparam int GAIN_FRAC = 27;
   localparam int LPF_SHIFT = 2;
   localparam int HPF_SHIFT = 10;
   localparam int INT_SHIFT = 4;
   localparam int INT_LEAK = 12;
   localparam int RMS_SHIFT = 8;

   // ==========================================================
   // Register byte offsets (arrays step by one word per channel)
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_GAIN = 8'h04;
   localparam logic [7:0] OFS_PHCAL = 8'h14;
   localparam logic [7:0] OFS_SINC = 8'h24;
   localparam logic [7:0] OFS_LPF = 8'h34;
   localparam logic [7:0] OFS_COMP = 8'h44;
   localparam logic [7:0] OFS_RMS = 8'h54;
   localparam logic [7:0] OFS_PEAK = 8'h68;
   localparam logic [7:0] OFS_ANGLE = 8'h6C;

   // ==========================================================
   // first_config_reg fields and reset values
   localparam int CFG_PHASE_INT_BIT = 0;
   localparam int CFG_NEUTRAL_INT_BIT = 1;
   localparam int CFG_HPF_DIS_BIT = 2;
   localparam int CFG_ISUM_SUB_BIT = 3;
   localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
   localparam logic [31:0] GAIN_RESET = 32'h00000000;
   localparam logic [31:0] PHCAL_RESET = 32'h00000000;
endpackage

// ### rtl/ccd_comp_chan.sv
// One current channel after sinc4: IIR low-pass with decimation, high-pass,
// integrator, gain and phase compensation. Strobes come from the parent on the same clock.
`timescale 1ns/1ps
module ccd_comp_chan #(
   parameter int SAMP_W = ccd_pkg::SAMP_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic sinc_stb,
   input wire logic lpf_stb,
   input wire logic hpf_disable,
   input wire logic integ_enable,
   input wire logic signed [SAMP_W-1:0] sinc_sample,
   input wire logic signed [31:0] gain_cal,
   input wire logic signed [31:0] phase_cal,
   output logic signed [SAMP_W-1:0] lowpass_sample,
   output logic signed [SAMP_W-1:0] comp_sample,
   output logic comp_stb
);
   import ccd_pkg::*;

   // Samples are widened to one 32-bit working word, so wider samples cannot be served
   if (SAMP_W > 32 || SAMP_W < 2) begin : g_bad_width
      $error("SAMP_W must lie between 2 and 32");
   end

   logic signed [31:0] x_in, lpf_reg, lpf_next, dc_reg, hp, int_reg, int_next, ii;
   logic signed [31:0] gg, g_prev_reg, pc;
   logic signed [63:0] gprod, pprod;
   logic comp_go_reg;

   // ==========================================================
   // IIR low-pass at the sinc rate, sampled every fourth output
   assign x_in = 32'(sinc_sample);
   assign lpf_next = lpf_reg + ((x_in - lpf_reg) >>> LPF_SHIFT);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lpf_reg <= '0;
         lowpass_sample <= '0;
      end else begin
         if (sinc_stb) lpf_reg <= lpf_next;
         if (lpf_stb) lowpass_sample <= SAMP_W'(lpf_next);
      end
   end

   // ==========================================================
   // Compensation chain, evaluated one cycle after the decimated sample lands
   assign hp = hpf_disable ? 32'(lowpass_sample) : 32'(lowpass_sample) - dc_reg;
   // Leaky integrator so a stray offset cannot wind the accumulator up forever
   assign int_next = int_reg + (hp >>> INT_SHIFT) - (int_reg >>> INT_LEAK);
   assign ii = integ_enable ? int_next : hp;
   assign gprod = ii * gain_cal;
   assign gg = ii + 32'(gprod >>> GAIN_FRAC);
   // Phase trim as a fractional blend toward the previous sample
   assign pprod = (gg - g_prev_reg) * phase_cal;
   assign pc = gg + 32'(pprod >>> GAIN_FRAC);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         comp_go_reg <= 1'b0;
         comp_stb <= 1'b0;
         dc_reg <= '0;
         int_reg <= '0;
         g_prev_reg <= '0;
         comp_sample <= '0;
      end else begin
         comp_go_reg <= lpf_stb;
         comp_stb <= comp_go_reg;
         if (comp_go_reg) begin
            dc_reg <= dc_reg + ((32'(lowpass_sample) - dc_reg) >>> HPF_SHIFT);
            int_reg <= integ_enable ? int_next : '0;
            g_prev_reg <= gg;
            comp_sample <= SAMP_W'(pc);
         end
      end
   end
endmodule // ccd_comp_chan

// ### rtl/ccd_datapath.sv
// Current channel datapath: sinc4 decimation, per-channel compensation, rms, sum rms,
// peak and zero-crossing angles, with a plain register port for the host.
// Assumes modulator words arrive on the DSP clock with mod_valid at the modulator rate.
//
// What this block does
// - Phase sinc4 outputs readable, updating at 16 kSPS.
// - IIR low-pass plus decimation gives readable 4 kSPS samples.
// - Gain and phase compensation produce 4 kSPS instantaneous current per channel.
// - Compensated currents feed rms computations.
// - Compensated phase currents (A, B, C, not neutral) drive peak detect; peak register updates at 4 kSPS.
// - Filtered rms for A, B, C and neutral at 4 kSPS.
// - Rms of phase sum plus or minus neutral at 4 kSPS.
// - Zero-crossing angles measured in ticks of the DSP clock divided by 97.
// - Neutral channel has its own gain and phase calibration.
// - Neutral integrator runs only when neutral_integrator_en is set.
// - Tamper measure mode stops neutral channel processing; sum rms keeps using the held neutral term.
// - Neutral feeds its own rms and the sum rms neutral term.
// - Neutral sinc4 output at 16 kSPS plus low-pass output.
// - Phase gain is one plus gain over two to the 27.
// - Phase integrators run only when phase_integrator_en is set.
// - High-pass on by default, bypassed when highpass_disable written one.
`timescale 1ns/1ps
module ccd_datapath #(
   parameter int MOD_W = ccd_pkg::MOD_W,
   parameter int SAMP_W = ccd_pkg::SAMP_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic mod_valid,
   input wire logic signed [MOD_W-1:0] mod_sample_a,
   input wire logic signed [MOD_W-1:0] mod_sample_b,
   input wire logic signed [MOD_W-1:0] mod_sample_c,
   input wire logic signed [MOD_W-1:0] mod_sample_n,
   input wire logic volt_zero_cross_a,
   input wire logic volt_zero_cross_b,
   input wire logic volt_zero_cross_c,
   input wire logic tamper_measure_mode,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import ccd_pkg::*;

   // ==========================================================
   // Elaboration checks
   if (SAMP_W != MOD_W + 8) begin : g_bad_width
      $error("SAMP_W must equal MOD_W plus 8 for the sinc4 gain");
   end
   if (SINC_DECIM != 4 || LPF_DECIM != 4) begin : g_bad_decim
      $error("decimation ratios must be 4");
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic signed [MOD_W-1:0] mod_in [4];
   logic signed [SAMP_W-1:0] sinc_reg [4];
   logic signed [SAMP_W-1:0] lpf_out [4];
   logic signed [SAMP_W-1:0] comp_out [4];
   logic [3:0] comp_stb_ch;
   logic [3:0] ch_en;
   logic [CFG_W-1:0] cfg_reg;
   logic signed [31:0] gain_reg [4];
   logic signed [31:0] phcal_reg [4];
   logic [31:0] rms_reg [5];
   logic signed [31:0] rms_in [5];
   logic [ANG_W-1:0] ang_cnt [4];
   logic [ANG_W-1:0] angle_reg [5];
   logic [3:0] start_ev;
   logic [2:0] izc;
   logic [2:0] prev_neg_reg;
   logic [3:0] sync1_reg, sync2_reg;
   logic [2:0] vzx_d_reg;
   logic tamper_q;
   logic [1:0] dcnt_reg, lpf_cnt_reg;
   logic sinc_stb, lpf_stb, comp_stb;
   logic [7:0] tick_cnt_reg;
   logic ang_tick;
   logic [31:0] peak_reg, peak_cand, rd_mux;
   logic peak_clr;
   logic signed [31:0] sum_cur;

   assign mod_in[0] = mod_sample_a;
   assign mod_in[1] = mod_sample_b;
   assign mod_in[2] = mod_sample_c;
   assign mod_in[3] = mod_sample_n;

   // ==========================================================
   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         vzx_d_reg <= '0;
      end else begin
         sync1_reg <= {tamper_measure_mode, volt_zero_cross_c, volt_zero_cross_b, volt_zero_cross_a};
         sync2_reg <= sync1_reg;
         vzx_d_reg <= sync2_reg[2:0];
      end
   end
   assign tamper_q = sync2_reg[3];
   // Neutral modulator treated as off while in tamper measure mode
   assign ch_en = {~tamper_q, 3'b111};

   // ==========================================================
   // First config register and calibration registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_reg <= CFG_RESET;
      end else if (reg_wr && reg_addr == OFS_CONFIG) begin
         cfg_reg <= reg_wdata[CFG_W-1:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < 4; k++) begin
            gain_reg[k] <= GAIN_RESET;
            phcal_reg[k] <= PHCAL_RESET;
         end
      end else if (reg_wr) begin
         for (int k = 0; k < 4; k++) begin
            if (reg_addr == OFS_GAIN + 8'(4 * k)) gain_reg[k] <= reg_wdata;
            if (reg_addr == OFS_PHCAL + 8'(4 * k)) phcal_reg[k] <= reg_wdata;
         end
      end
   end

   // ==========================================================
   // Shared decimation counters keep all four channels in phase
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dcnt_reg <= '0;
         sinc_stb <= 1'b0;
         lpf_cnt_reg <= '0;
      end else begin
         if (mod_valid) dcnt_reg <= dcnt_reg + 2'd1;
         sinc_stb <= mod_valid && dcnt_reg == 2'(SINC_DECIM - 1);
         if (sinc_stb) lpf_cnt_reg <= lpf_cnt_reg + 2'd1;
      end
   end
   assign lpf_stb = sinc_stb && lpf_cnt_reg == 2'(LPF_DECIM - 1);
   assign comp_stb = comp_stb_ch[0];

   // ==========================================================
   // Per-channel sinc4 (CIC, decimate by 4) and compensation
   for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      logic signed [SAMP_W-1:0] integ_reg [4];
      logic signed [SAMP_W-1:0] dly_reg [4];
      logic signed [SAMP_W-1:0] comb [5];
      assign comb[0] = integ_reg[3];
      for (genvar s = 0; s < 4; s++) begin : g_comb
         assign comb[s+1] = comb[s] - dly_reg[s];
      end
      // Wrapping arithmetic is intended: CIC integrators overflow harmlessly
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            integ_reg <= '{default: '0};
            dly_reg <= '{default: '0};
            sinc_reg[ch] <= '0;
         end else if (!ch_en[ch]) begin
            integ_reg <= '{default: '0};
            dly_reg <= '{default: '0};
            sinc_reg[ch] <= '0;
         end else begin
            if (mod_valid) begin
               integ_reg[0] <= integ_reg[0] + SAMP_W'(mod_in[ch]);
               for (int s = 1; s < 4; s++) integ_reg[s] <= integ_reg[s] + integ_reg[s-1];
            end
            if (mod_valid && dcnt_reg == 2'(SINC_DECIM - 1)) begin
               for (int s = 0; s < 4; s++) dly_reg[s] <= comb[s];
               sinc_reg[ch] <= comb[4];
            end
         end
      end

      ccd_comp_chan #(.SAMP_W(SAMP_W)) u_comp (
         .clock(clock),
         .rst(rst),
         .sinc_stb(sinc_stb && ch_en[ch]),
         .lpf_stb(lpf_stb && ch_en[ch]),
         .hpf_disable(cfg_reg[CFG_HPF_DIS_BIT]),
         .integ_enable(ch == 3 ? cfg_reg[CFG_NEUTRAL_INT_BIT] : cfg_reg[CFG_PHASE_INT_BIT]),
         .sinc_sample(sinc_reg[ch]),
         .gain_cal(gain_reg[ch]),
         .phase_cal(phcal_reg[ch]),
         .lowpass_sample(lpf_out[ch]),
         .comp_sample(comp_out[ch]),
         .comp_stb(comp_stb_ch[ch])
      );
      assign rms_in[ch] = 32'(comp_out[ch]);
   end

   // ==========================================================
   // Sum of instantaneous currents, neutral added or subtracted
   always_comb begin
      sum_cur = rms_in[0] + rms_in[1] + rms_in[2];
      sum_cur = cfg_reg[CFG_ISUM_SUB_BIT] ? sum_cur - rms_in[3] : sum_cur + rms_in[3];
   end
   assign rms_in[4] = sum_cur;

   // Integer square root, one result bit per step
   function automatic logic [31:0] isqrt(input logic [63:0] v);
      logic [63:0] rem;
      logic [63:0] trial;
      logic [31:0] root;
      rem = '0;
      root = '0;
      for (int i = 31; i >= 0; i--) begin
         rem = {rem[61:0], v[2*i+1 -: 2]};
         trial = {30'h0, root, 2'b01};
         if (rem >= trial) begin
            rem = rem - trial;
            root = {root[30:0], 1'b1};
         end else begin
            root = {root[30:0], 1'b0};
         end
      end
      return root;
   endfunction

   // ==========================================================
   // Filter-based rms: low-passed square, then square root
   for (genvar k = 0; k < 5; k++) begin : g_rms
      logic signed [63:0] ms_reg, ms_next, sq;
      assign sq = rms_in[k] * rms_in[k];
      assign ms_next = ms_reg + ((sq - ms_reg) >>> RMS_SHIFT);
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            ms_reg <= '0;
            rms_reg[k] <= '0;
         end else if (comp_stb && (k != 3 || !tamper_q)) begin
            ms_reg <= ms_next;
            rms_reg[k] <= isqrt(ms_next);
         end
      end
   end

   // ==========================================================
   // Peak detect over phase currents; a read restarts the hold
   always_comb begin
      peak_cand = '0;
      for (int p = 0; p < 3; p++) begin
         if ((rms_in[p] < 0 ? -rms_in[p] : rms_in[p]) > $signed(peak_cand)) begin
            peak_cand = rms_in[p] < 0 ? -rms_in[p] : rms_in[p];
         end
      end
   end
   assign peak_clr = reg_rd && reg_addr == OFS_PEAK;

   // New sample wins over a coincident read clear so no peak is lost
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         peak_reg <= '0;
      end else if (comp_stb) begin
         peak_reg <= (peak_clr || peak_cand > peak_reg) ? peak_cand : peak_reg;
      end else if (peak_clr) begin
         peak_reg <= '0;
      end
   end

   // ==========================================================
   // Angle timebase: one tick per ANGLE_TICK_CYCLES (97) DSP clock cycles
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= (tick_cnt_reg == ANGLE_TICK_LAST) ? 8'h00 : tick_cnt_reg + 8'h01;
      end
   end
   assign ang_tick = tick_cnt_reg == ANGLE_TICK_LAST;

   // Current zero crossings from the sinc4 sign, negative to non-negative
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_neg_reg <= '0;
      end else if (sinc_stb) begin
         for (int p = 0; p < 3; p++) prev_neg_reg[p] <= sinc_reg[p][SAMP_W-1];
      end
   end
   for (genvar p = 0; p < 3; p++) begin : g_izc
      assign izc[p] = sinc_stb && prev_neg_reg[p] && !sinc_reg[p][SAMP_W-1];
   end
   assign start_ev = {izc[0], sync2_reg[2:0] & ~vzx_d_reg};

   // Counters 0..2 start on voltage crossings, counter 3 on the IA crossing
   for (genvar k = 0; k < 4; k++) begin : g_acnt
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            ang_cnt[k] <= '0;
         end else if (start_ev[k]) begin
            ang_cnt[k] <= '0;
         end else if (ang_tick && ang_cnt[k] != {ANG_W{1'b1}}) begin
            ang_cnt[k] <= ang_cnt[k] + 16'h0001;
         end
      end
   end

   // Results 0..2: voltage to current; 3: IA to IB; 4: IA to IC
   for (genvar k = 0; k < 5; k++) begin : g_angle
      localparam int SRC = (k < 3) ? k : 3;
      localparam int STOP = (k < 3) ? k : k - 2;
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            angle_reg[k] <= '0;
         end else if (izc[STOP]) begin
            angle_reg[k] <= ang_cnt[SRC];
         end
      end
   end

   // ==========================================================
   // Register read port; unmapped offsets read zero
   always_comb begin
      rd_mux = '0;
      if (reg_addr == OFS_CONFIG) rd_mux = 32'(cfg_reg);
      if (reg_addr == OFS_PEAK) rd_mux = peak_reg;
      for (int k = 0; k < 4; k++) begin
         if (reg_addr == OFS_GAIN + 8'(4 * k)) rd_mux = gain_reg[k];
         if (reg_addr == OFS_PHCAL + 8'(4 * k)) rd_mux = phcal_reg[k];
         if (reg_addr == OFS_SINC + 8'(4 * k)) rd_mux = 32'(sinc_reg[k]);
         if (reg_addr == OFS_LPF + 8'(4 * k)) rd_mux = 32'(lpf_out[k]);
         if (reg_addr == OFS_COMP + 8'(4 * k)) rd_mux = 32'(comp_out[k]);
      end
      for (int k = 0; k < 5; k++) begin
         if (reg_addr == OFS_RMS + 8'(4 * k)) rd_mux = rms_reg[k];
         if (reg_addr == OFS_ANGLE + 8'(4 * k)) rd_mux = 32'(angle_reg[k]);
      end
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   // ==========================================================
   // Assertions
   sequence s_comp_ready;
      ##2 comp_stb;
   endsequence
   sequence s_sinc_gap;
      !sinc_stb [*3];
   endsequence

   a_sinc_from_input: assert property (sinc_stb |-> $past(mod_valid))
      else $error("sinc strobe without modulator word");
   a_sinc_decim_gap: assert property (sinc_stb |=> s_sinc_gap)
      else $error("sinc strobes closer than the decimation ratio");
   a_lpf_phase_aligned: assert property (lpf_stb |-> sinc_stb && lpf_cnt_reg == 2'd3)
      else $error("4 kSPS strobe out of phase with sinc strobe");
   a_comp_after_lpf: assert property (lpf_stb |-> s_comp_ready)
      else $error("compensated sample late after low-pass strobe");
   a_rms_hold_stable: assert property (!comp_stb |=> $stable(rms_reg[0]) && $stable(rms_reg[4]))
      else $error("rms changed between strobes");
   a_peak_covers_sample: assert property (comp_stb |=> peak_reg >= $past(peak_cand))
      else $error("peak below latest sample");
   a_neutral_frozen: assert property ($past(tamper_q, 2) && $past(tamper_q) |-> $stable(sinc_reg[3]))
      else $error("neutral channel active in tamper mode");
   a_angle_latch_value: assert property (izc[0] |=> angle_reg[0] == $past(ang_cnt[0]))
      else $error("angle did not capture counter");
   a_angle_tick_spacing: assert property (ang_tick |=> !ang_tick)
      else $error("angle ticks back to back");
   a_hpf_default_on: assert property ($fell(rst) |-> !cfg_reg[CFG_HPF_DIS_BIT])
      else $error("high-pass not enabled after reset");
endmodule // ccd_datapath

// ### bench/ccd_mod_src.sv
// Stand-in for the four current modulators feeding the datapath.
// Assumes the bench clock and reset; one word set every second cycle while run is high.
`timescale 1ns/1ps
module ccd_mod_src (
   input wire logic clock,
   input wire logic rst,
   input wire logic run,
   input wire logic signed [15:0] lvl [4],
   output logic mod_valid,
   output logic signed [15:0] word [4]
);
   logic phase_reg;
   // ==========================================================
   // Word pacing
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_reg <= 1'b0;
         mod_valid <= 1'b0;
      end else begin
         phase_reg <= run ? ~phase_reg : 1'b0;
         mod_valid <= run & phase_reg;
      end
   end
   // Inverse between words, so a stale word never passes for a fresh one
   always_ff @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         word[i] <= (run & phase_reg) ? lvl[i] : ~lvl[i];
      end
   end
endmodule // ccd_mod_src

// ### bench/tb.sv
// Self-checking bench for the current channel datapath.
// Assumes ccd_pkg offsets; register reads are checked one cycle after the strobe.
`timescale 1ns/1ps
module tb;
   import ccd_pkg::*;
   typedef struct {logic signed [31:0] val; int tol; string what;} ccd_note_s;
   logic clock, rst, run, tamper, reg_wr, reg_rd, rd_d, mod_valid, vza;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic signed [15:0] lvl [4];
   logic signed [15:0] w [4];
   logic signed [31:0] diff, pk;
   ccd_note_s notes [$];
   ccd_note_s nt;
   int n_fail, checks_done, seed;
   ccd_mod_src src (.clock(clock), .rst(rst), .run(run), .lvl(lvl), .mod_valid(mod_valid), .word(w));
   ccd_datapath dut (.clock(clock), .rst(rst), .mod_valid(mod_valid), .mod_sample_a(w[0]),
      .mod_sample_b(w[1]), .mod_sample_c(w[2]), .mod_sample_n(w[3]), .volt_zero_cross_a(vza),
      .volt_zero_cross_b(1'b0), .volt_zero_cross_c(1'b0), .tamper_measure_mode(tamper),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // ==========================================================
   // Clock and watchdog
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      repeat (60000) @(posedge clock);
      n_fail++;
      $display("[FAIL] watchdog expected finish seen hang");
      wrap_up();
   end
   function automatic logic signed [31:0] sc(int k, logic signed [15:0] x);
      return k * int'(x);
   endfunction
   function automatic logic signed [31:0] ab(logic signed [31:0] x);
      return x < 0 ? -x : x;
   endfunction
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // Note the expectation, then strobe for one cycle
   task automatic rd(logic [7:0] a, logic signed [31:0] e, int t, string s);
      @(posedge clock);
      notes.push_back('{e, t, s});
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Read monitor: mid-cycle sampling keeps clear of the launching edge
   always @(posedge clock) rd_d <= reg_rd;
   always @(negedge clock) begin
      if (rd_d) begin
         nt = notes.pop_front();
         diff = $signed(reg_rdata) - nt.val;
         checks_done++;
         if ($isunknown(reg_rdata) || diff > nt.tol || diff < -nt.tol) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nt.what, nt.val, reg_rdata);
         end
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      seed = 4658;
      {rst, run, tamper, reg_wr, reg_rd, vza, reg_addr, reg_wdata} = {1'b1, 45'h0};
      for (int i = 0; i < 4; i++) lvl[i] = 16'($random(seed) % 12000);
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(OFS_CONFIG, 0, 0, "config");
      for (int i = 0; i < 8; i++) rd(OFS_GAIN + 8'(4 * i), 0, 0, "cal");
      rd(8'h80, 0, 0, "unmapped");
      rd(8'h05, 0, 0, "misaligned");
      wr(OFS_SINC, 32'h12345);
      rd(OFS_SINC, 0, 0, "sinc_ro");
      for (int i = 0; i < 8; i++) begin
         d = $random(seed);
         wr(OFS_GAIN + 8'(4 * i), d);
         rd(OFS_GAIN + 8'(4 * i), d, 0, "cal");
      end
      wr(OFS_CONFIG, 32'h4);
      rd(OFS_CONFIG, 4, 0, "config");
      $display("test registers done");
      // Gain 1.5 on A, minus one on neutral, no phase correction
      for (int i = 0; i < 8; i++) wr(OFS_GAIN + 8'(4 * i), 32'h0);
      wr(OFS_GAIN, 32'h04000000);
      wr(OFS_GAIN + 8'hC, 32'hF0000000);
      run <= 1'b1;
      // Long enough for the rms filter to settle to within a fraction of a percent
      repeat (36000) @(posedge clock);
      run <= 1'b0;
      repeat (100) @(posedge clock);
      for (int i = 0; i < 4; i++) begin
         rd(OFS_SINC + 8'(4 * i), sc(256, lvl[i]), 0, "sinc");
         rd(OFS_LPF + 8'(4 * i), sc(256, lvl[i]), 4, "lowpass");
      end
      rd(OFS_COMP, sc(384, lvl[0]), 8, "comp_a");
      rd(OFS_COMP + 8'h4, sc(256, lvl[1]), 4, "comp_b");
      rd(OFS_COMP + 8'h8, sc(256, lvl[2]), 4, "comp_c");
      rd(OFS_COMP + 8'hC, sc(-256, lvl[3]), 4, "comp_n");
      pk = 0;
      for (int i = 0; i < 3; i++) begin
         if (ab(sc(i == 0 ? 384 : 256, lvl[i])) > pk) pk = ab(sc(i == 0 ? 384 : 256, lvl[i]));
      end
      rd(OFS_PEAK, pk, 8, "peak");
      rd(OFS_PEAK, 0, 0, "peak_cleared");
      // Rms of a steady level is its magnitude; slack covers the filter tail
      rd(OFS_RMS, ab(sc(384, lvl[0])), ab(sc(384, lvl[0])) / 64 + 16, "rms_a");
      rd(OFS_RMS + 8'hC, ab(sc(256, lvl[3])), ab(sc(256, lvl[3])) / 64 + 16, "rms_n");
      pk = ab(sc(384, lvl[0]) + sc(256, lvl[1]) + sc(256, lvl[2]) - sc(256, lvl[3]));
      rd(OFS_RMS + 8'h10, pk, pk / 64 + 16, "sum_rms");
      repeat (200) @(posedge clock);
      rd(OFS_SINC, sc(256, lvl[0]), 0, "sinc_hold");
      $display("test datapath done");
      // Tamper mode clears and freezes only the neutral channel
      tamper <= 1'b1;
      run <= 1'b1;
      repeat (500) @(posedge clock);
      run <= 1'b0;
      repeat (100) @(posedge clock);
      rd(OFS_SINC + 8'hC, 0, 0, "tamper_sinc_n");
      rd(OFS_LPF + 8'hC, sc(256, lvl[3]), 4, "tamper_lpf_n");
      rd(OFS_COMP + 8'hC, sc(-256, lvl[3]), 4, "tamper_comp_n");
      rd(OFS_SINC, sc(256, lvl[0]), 0, "tamper_sinc_a");
      tamper <= 1'b0;
      $display("test tamper done");
      // Voltage crossing on A, then 970 cycles later current A crosses upward;
      // tick phase is unknown here, hence one count of slack
      lvl[0] <= -16'sd3000;
      run <= 1'b1;
      repeat (300) @(posedge clock);
      vza <= 1'b1;
      repeat (970) @(posedge clock);
      lvl[0] <= 16'sd3000;
      repeat (200) @(posedge clock);
      run <= 1'b0;
      rd(OFS_ANGLE, 970 / ANGLE_TICK_CYCLES, 1, "angle_a");
      $display("test angle done");
      repeat (3) @(posedge clock);
      wrap_up();
   end
endmodule // tb
